// ===== common/ccr_pkg.sv
package ccr_pkg;
    // ******************************
    // status word layout
    // ******************************
    localparam int STW_WIDTH       = 16;
    localparam int BIT_STOP_EN     = 15;
    localparam int BIT_MAC_HI_OVF  = 14;
    localparam int BIT_HALF_CARRY  = 13;
    localparam int BIT_MAC_EXT_OVF = 12;
    localparam int BIT_NEGATIVE    = 11;
    localparam int BIT_ZERO        = 10;
    localparam int BIT_OVERFLOW    = 9;
    localparam int BIT_CARRY       = 8;
    localparam int PRIO_MSB        = 7;
    localparam int PRIO_LSB        = 5;
    localparam int BIT_SATURATE    = 4;
    localparam int PCX_MSB         = 3;
    localparam int PCX_LSB         = 0;
    localparam int PRIO_WIDTH      = 3;
    localparam int PCX_WIDTH       = 4;
    localparam int PC_WIDTH        = 16;
    localparam int FETCH_WIDTH     = 20;
    // ******************************
    // accumulator layout
    // ******************************
    localparam int MAC_WIDTH       = 36;
    localparam int MAC_HI_MSB      = 35;
    localparam int MAC_HI_LSB      = 16;
    localparam int MAC_LO_MSB      = 15;
    localparam int MAC_EXT_BIT     = 31;
    localparam int RESULT_WIDTH    = 16;
    localparam logic [15:0] STW_RESET = 16'h0000;
    // ******************************
    // flag update select bits
    // ******************************
    localparam int UPD_WIDTH = 8;
    localparam int UPD_N     = 0;
    localparam int UPD_Z     = 1;
    localparam int UPD_V     = 2;
    localparam int UPD_C     = 3;
    localparam int UPD_H     = 4;
    localparam int UPD_EV    = 5;
    localparam int UPD_MV    = 6;
    localparam int UPD_SHIFT = 7;

    typedef enum logic [2:0] {
        HALT_RUN     = 3'b001,
        HALT_STOPPED = 3'b010,
        HALT_NOP     = 3'b100
    } ccr_halt_type;
endpackage

// ===== design/ccr_sat_read.sv
`timescale 1ns/1ps
module ccr_sat_read
    import ccr_pkg::*;
(
    input  wire logic [ccr_pkg::MAC_WIDTH-1:0] mac_in,
    input  wire logic                          sign_before_in,
    input  wire logic                          saturate_in,
    input  wire logic                          ext_ovf_in,
    input  wire logic                          hi_ovf_in,
    input  wire logic                          rounded_in,
    output logic [ccr_pkg::RESULT_WIDTH-1:0]   value_out
);
    logic [RESULT_WIDTH:0] rounded;
    always_comb begin
        // round on bit 15, return bits 31:16
        rounded = {1'b0, mac_in[MAC_EXT_BIT:MAC_HI_LSB]} + {16'h0000, mac_in[MAC_LO_MSB]};
        if (saturate_in && (ext_ovf_in || hi_ovf_in)) begin
            value_out = sign_before_in ? 16'h8000 : 16'h7fff;
        end else if (rounded_in) begin
            value_out = rounded[RESULT_WIDTH-1:0];
        end else begin
            value_out = mac_in[MAC_EXT_BIT:MAC_HI_LSB];
        end
    end
endmodule

// ===== design/ccr_core.sv
`timescale 1ns/1ps
// What this block does
// - status word is 16 bits with fixed flag, mask, mode and extension fields
// - halt instruction stops clock when stop-enable is 0, else acts as no-op
// - mac high overflow flag sets on overflow into accumulator bit 35
// - half carry sets on add carry out of bit 3
// - mac extension overflow flag sets on overflow into accumulator bit 31
// - negative flag follows result most significant bit
// - zero flag sets when whole result is zero
// - overflow flag sets on two's complement signed overflow
// - carry takes arithmetic carry or borrow and shift-out bit
// - three-bit priority field masks interrupt requests
// - saturate mode clamps rounded and truncated accumulator reads on overflow
// - fetch address is extension field above 16-bit program counter
// - accumulator is 36 bits, upper 35:16 and lower 15:0
module ccr_core
    import ccr_pkg::*;
(
    input  wire logic                            clock_in,
    input  wire logic                            rst_b_in,
    input  wire logic                            stw_write_in,
    input  wire logic [ccr_pkg::STW_WIDTH-1:0]   stw_wdata_in,
    input  wire logic                            flag_update_in,
    input  wire logic [ccr_pkg::UPD_WIDTH-1:0]   flag_select_in,
    input  wire logic [ccr_pkg::RESULT_WIDTH-1:0] result_in,
    input  wire logic                            carry_in,
    input  wire logic                            overflow_in,
    input  wire logic                            half_carry_in,
    input  wire logic                            shift_out_in,
    input  wire logic                            mac_load_in,
    input  wire logic [ccr_pkg::MAC_WIDTH-1:0]   mac_wdata_in,
    input  wire logic                            halt_exec_in,
    input  wire logic                            wake_in,
    input  wire logic [ccr_pkg::PC_WIDTH-1:0]    pc_in,
    input  wire logic [2:0]                      irq_level_in,
    input  wire logic                            irq_req_in,
    input  wire logic                            acc_read_in,
    input  wire logic                            acc_read_rounded_in,
    output logic [ccr_pkg::STW_WIDTH-1:0]        status_word_out,
    output logic [ccr_pkg::MAC_WIDTH-1:0]        mac_accumulator_out,
    output logic [ccr_pkg::FETCH_WIDTH-1:0]      fetch_addr_out,
    output logic                                 core_clock_stop_out,
    output logic                                 halt_nop_out,
    output logic                                 irq_take_out,
    output logic [ccr_pkg::RESULT_WIDTH-1:0]     acc_read_data_out
);
    import ccr_pkg::*;

    // ******************************
    // status word register
    // ******************************
    logic [STW_WIDTH-1:0] stw_r;
    logic [STW_WIDTH-1:0] stw_nxt;
    logic [MAC_WIDTH-1:0] mac_r;
    logic                 mac_sign_r;
    logic                 ext_ovf_evt;
    logic                 hi_ovf_evt;
    logic [RESULT_WIDTH-1:0] sat_value;
    ccr_halt_type         halt_r;

    // accumulator overflow events from a 36-bit load
    always_comb begin
        ext_ovf_evt = mac_load_in && !((&mac_wdata_in[MAC_HI_MSB:MAC_EXT_BIT])
                      || (~|mac_wdata_in[MAC_HI_MSB:MAC_EXT_BIT]));
        hi_ovf_evt  = mac_load_in && (mac_wdata_in[MAC_HI_MSB] != mac_r[MAC_HI_MSB])
                      && (mac_wdata_in[MAC_HI_MSB] != mac_wdata_in[MAC_HI_MSB-1]);
    end

    always_comb begin
        stw_nxt = stw_r;
        if (stw_write_in) begin
            stw_nxt = stw_wdata_in;
        end
        if (flag_update_in) begin
            if (flag_select_in[UPD_N]) stw_nxt[BIT_NEGATIVE] = result_in[RESULT_WIDTH-1];
            if (flag_select_in[UPD_Z]) stw_nxt[BIT_ZERO] = (result_in == 16'h0000);
            if (flag_select_in[UPD_V]) stw_nxt[BIT_OVERFLOW] = overflow_in;
            if (flag_select_in[UPD_C]) begin
                stw_nxt[BIT_CARRY] = flag_select_in[UPD_SHIFT] ? shift_out_in : carry_in;
            end
            if (flag_select_in[UPD_H]) stw_nxt[BIT_HALF_CARRY] = half_carry_in;
            if (flag_select_in[UPD_EV]) stw_nxt[BIT_MAC_EXT_OVF] = 1'b0;
            if (flag_select_in[UPD_MV]) stw_nxt[BIT_MAC_HI_OVF] = 1'b0;
        end
        // overflow events win over any clear in the same cycle
        if (ext_ovf_evt) stw_nxt[BIT_MAC_EXT_OVF] = 1'b1;
        if (hi_ovf_evt)  stw_nxt[BIT_MAC_HI_OVF] = 1'b1;
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stw_r <= STW_RESET;
        end else begin
            stw_r <= stw_nxt;
        end
    end

    // ******************************
    // mac accumulator
    // ******************************
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mac_r      <= '0;
            mac_sign_r <= 1'b0;
        end else if (mac_load_in) begin
            mac_r      <= mac_wdata_in;
            mac_sign_r <= mac_r[MAC_HI_MSB];
        end
    end

    ccr_sat_read u_sat (
        .mac_in         (mac_r),
        .sign_before_in (mac_sign_r),
        .saturate_in    (stw_r[BIT_SATURATE]),
        .ext_ovf_in     (stw_r[BIT_MAC_EXT_OVF]),
        .hi_ovf_in      (stw_r[BIT_MAC_HI_OVF]),
        .rounded_in     (acc_read_rounded_in),
        .value_out      (sat_value)
    );

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            acc_read_data_out <= '0;
        end else if (acc_read_in) begin
            acc_read_data_out <= sat_value;
        end
    end

    // ******************************
    // halt control
    // ******************************
    // clock stop is held until wake; the stop-enable bit is sampled when
    // the instruction executes, not while halted
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            halt_r <= HALT_RUN;
        end else begin
            case (halt_r)
                HALT_RUN: begin
                    if (halt_exec_in) begin
                        halt_r <= stw_r[BIT_STOP_EN] ? HALT_NOP : HALT_STOPPED;
                    end
                end
                HALT_STOPPED: begin
                    if (wake_in) halt_r <= HALT_RUN;
                end
                HALT_NOP: halt_r <= HALT_RUN;
                default:  halt_r <= HALT_RUN;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            core_clock_stop_out <= 1'b0;
            halt_nop_out        <= 1'b0;
        end else begin
            core_clock_stop_out <= (halt_r == HALT_RUN) ? (halt_exec_in && !stw_r[BIT_STOP_EN])
                                 : (halt_r == HALT_STOPPED && !wake_in);
            halt_nop_out        <= (halt_r == HALT_RUN) && halt_exec_in && stw_r[BIT_STOP_EN];
        end
    end

    // ******************************
    // interrupt mask and fetch address
    // ******************************
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_take_out   <= 1'b0;
            fetch_addr_out <= '0;
        end else begin
            // level 7 cannot be masked
            irq_take_out   <= irq_req_in && ((irq_level_in > stw_r[PRIO_MSB:PRIO_LSB])
                              || (irq_level_in == 3'h7));
            fetch_addr_out <= {stw_nxt[PCX_MSB:PCX_LSB], pc_in};
        end
    end

    assign status_word_out     = stw_r;
    assign mac_accumulator_out = mac_r;

    // ******************************
    // checks
    // ******************************
    zero_flag_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        flag_update_in && flag_select_in[UPD_Z] && !stw_write_in
        |=> stw_r[BIT_ZERO] == ($past(result_in) == 16'h0000))
        else $error("zero flag wrong");
    neg_flag_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        flag_update_in && flag_select_in[UPD_N]
        |=> stw_r[BIT_NEGATIVE] == $past(result_in[15]))
        else $error("negative flag wrong");
    flag_hold_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !flag_update_in && !stw_write_in && !mac_load_in |=> $stable(stw_r))
        else $error("status word changed without cause");
    ext_ovf_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        ext_ovf_evt |=> stw_r[BIT_MAC_EXT_OVF])
        else $error("extension overflow not set");
    hi_ovf_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        hi_ovf_evt |=> stw_r[BIT_MAC_HI_OVF])
        else $error("high overflow not set");
    halt_stop_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        halt_r == HALT_RUN && halt_exec_in && !stw_r[BIT_STOP_EN]
        |=> core_clock_stop_out && !halt_nop_out)
        else $error("halt did not stop clock");
    halt_nop_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        halt_r == HALT_RUN && halt_exec_in && stw_r[BIT_STOP_EN]
        |=> halt_nop_out && !core_clock_stop_out ##1 !halt_nop_out)
        else $error("halt nop wrong");
    fetch_addr_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        1'b1 |=> fetch_addr_out == {stw_r[PCX_MSB:PCX_LSB], $past(pc_in)})
        else $error("fetch address wrong");
    irq_mask_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        irq_req_in && irq_level_in <= stw_r[PRIO_MSB:PRIO_LSB] && irq_level_in != 3'h7
        |=> !irq_take_out)
        else $error("masked interrupt taken");
    sat_read_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        acc_read_in && stw_r[BIT_SATURATE] && stw_r[BIT_MAC_EXT_OVF]
        |=> acc_read_data_out == ($past(mac_sign_r) ? 16'h8000 : 16'h7fff))
        else $error("saturated read wrong");
    write_word_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        stw_write_in && !flag_update_in && !mac_load_in |=> stw_r == $past(stw_wdata_in))
        else $error("status word write lost");

    // ******************************
    // flag source checks
    // ******************************
    // each selected flag must follow its own source, not a neighbour's
    carry_src_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        flag_update_in && flag_select_in[UPD_C] && !flag_select_in[UPD_SHIFT]
        |=> stw_r[BIT_CARRY] == $past(carry_in))
        else $error("carry flag wrong");

    shift_carry_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        flag_update_in && flag_select_in[UPD_C] && flag_select_in[UPD_SHIFT]
        |=> stw_r[BIT_CARRY] == $past(shift_out_in))
        else $error("shift carry wrong");

    ovf_flag_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        flag_update_in && flag_select_in[UPD_V]
        |=> stw_r[BIT_OVERFLOW] == $past(overflow_in))
        else $error("overflow flag wrong");

    half_carry_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        flag_update_in && flag_select_in[UPD_H]
        |=> stw_r[BIT_HALF_CARRY] == $past(half_carry_in))
        else $error("half carry flag wrong");

    ext_clear_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        flag_update_in && flag_select_in[UPD_EV] && !ext_ovf_evt
        |=> !stw_r[BIT_MAC_EXT_OVF])
        else $error("extension overflow not cleared");

    hi_clear_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        flag_update_in && flag_select_in[UPD_MV] && !hi_ovf_evt
        |=> !stw_r[BIT_MAC_HI_OVF])
        else $error("high overflow not cleared");

    // ******************************
    // halt and interrupt checks
    // ******************************
    stop_hold_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        halt_r == HALT_STOPPED && !wake_in
        |=> core_clock_stop_out && halt_r == HALT_STOPPED)
        else $error("clock stop dropped early");

    wake_run_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        halt_r == HALT_STOPPED && wake_in
        |=> !core_clock_stop_out && halt_r == HALT_RUN)
        else $error("wake did not restart");

    irq_top_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        irq_req_in && irq_level_in == 3'h7
        |=> irq_take_out)
        else $error("top level interrupt lost");

    irq_above_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        irq_req_in && irq_level_in > stw_r[PRIO_MSB:PRIO_LSB]
        |=> irq_take_out)
        else $error("unmasked interrupt lost");

    irq_idle_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !irq_req_in
        |=> !irq_take_out)
        else $error("interrupt taken without request");

    // ******************************
    // accumulator checks
    // ******************************
    mac_load_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        mac_load_in
        |=> mac_accumulator_out == $past(mac_wdata_in))
        else $error("accumulator load lost");

    mac_hold_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !mac_load_in
        |=> $stable(mac_accumulator_out))
        else $error("accumulator changed without load");

    sign_track_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        mac_load_in
        |=> mac_sign_r == $past(mac_r[MAC_HI_MSB]))
        else $error("saturation sign wrong");

    hi_sat_read_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        acc_read_in && stw_r[BIT_SATURATE] && stw_r[BIT_MAC_HI_OVF]
        |=> acc_read_data_out == ($past(mac_sign_r) ? 16'h8000 : 16'h7fff))
        else $error("high overflow read not saturated");

    trunc_read_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        acc_read_in && !acc_read_rounded_in
        && !(stw_r[BIT_SATURATE] && (stw_r[BIT_MAC_EXT_OVF] || stw_r[BIT_MAC_HI_OVF]))
        |=> acc_read_data_out == $past(mac_r[MAC_EXT_BIT:MAC_HI_LSB]))
        else $error("truncated read wrong");

    round_read_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        acc_read_in && acc_read_rounded_in
        && !(stw_r[BIT_SATURATE] && (stw_r[BIT_MAC_EXT_OVF] || stw_r[BIT_MAC_HI_OVF]))
        |=> acc_read_data_out == $past(mac_r[MAC_EXT_BIT:MAC_HI_LSB])
            + {15'h0000, $past(mac_r[MAC_LO_MSB])})
        else $error("rounded read wrong");

    read_hold_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !acc_read_in
        |=> $stable(acc_read_data_out))
        else $error("read data changed without read");
endmodule

// ===== verif/ccr_alu_model.sv
`timescale 1ns/1ps
module ccr_alu_model (
    input  wire logic [15:0] a_in,
    input  wire logic [15:0] b_in,
    output logic      [15:0] sum_out,
    output logic             carry_out,
    output logic             overflow_out,
    output logic             half_carry_out
);
    logic [16:0] wide;
    logic [4:0]  low_nib;
    assign wide = {1'b0, a_in} + {1'b0, b_in};
    assign low_nib = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
    assign sum_out = wide[15:0];
    assign carry_out = wide[16];
    assign overflow_out = (a_in[15] == b_in[15]) && (wide[15] != a_in[15]);
    // nibble carry out of bit 3 feeds the half carry flag
    assign half_carry_out = low_nib[4];
endmodule

// ===== verif/condition_code_register_bench.sv
`timescale 1ns/1ps
module condition_code_register_bench;
    import ccr_pkg::*;
    logic        clock_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        stw_write_in = 1'b0, flag_update_in = 1'b0, shift_out_in = 1'b0;
    logic        mac_load_in = 1'b0, halt_exec_in = 1'b0, wake_in = 1'b0;
    logic        irq_req_in = 1'b0, acc_read_in = 1'b0, acc_read_rounded_in = 1'b0;
    logic        carry_in, overflow_in, half_carry_in, core_clock_stop_out;
    logic        halt_nop_out, irq_take_out;
    logic [15:0] stw_wdata_in = '0, pc_in = '0, op_a = '0, op_b = '0;
    logic [15:0] result_in, status_word_out, acc_read_data_out, sw;
    logic [7:0]  flag_select_in = '0;
    logic [35:0] mac_wdata_in = '0, mac_accumulator_out;
    logic [2:0]  irq_level_in = '0;
    logic [19:0] fetch_addr_out;
    logic [31:0] corner [3] = '{32'h0000_0000, 32'h7fff_0001, 32'hffff_0001};
    logic [35:0] mac_tab [3] = '{36'h0_8000_0000, 36'h8_0000_0000, 36'hf_ffff_0000};
    logic [15:0] sat_tab [3] = '{16'h7fff, 16'h7fff, 16'h8000};
    int          mismatches = 0;
    int          check_count = 0;

    ccr_alu_model i_ccr_alu_model (.a_in(op_a), .b_in(op_b), .sum_out(result_in),
        .carry_out(carry_in), .overflow_out(overflow_in), .half_carry_out(half_carry_in));
    ccr_core i_ccr_core (.clock_in, .rst_b_in, .stw_write_in, .stw_wdata_in, .flag_update_in,
        .flag_select_in, .result_in, .carry_in, .overflow_in, .half_carry_in, .shift_out_in,
        .mac_load_in, .mac_wdata_in, .halt_exec_in, .wake_in, .pc_in, .irq_level_in,
        .irq_req_in, .acc_read_in, .acc_read_rounded_in, .status_word_out,
        .mac_accumulator_out, .fetch_addr_out, .core_clock_stop_out, .halt_nop_out,
        .irq_take_out, .acc_read_data_out);

    // ******************************
    // helpers
    // ******************************
    task automatic check(input logic [35:0] seen, input logic [35:0] expd);
        check_count++;
        if (seen !== expd) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic write_sw(input logic [15:0] v);
        stw_write_in = 1'b1;
        stw_wdata_in = v;
        @(negedge clock_in);
        stw_write_in = 1'b0;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    function automatic logic [15:0] add_flags(input logic [15:0] old, a, b,
                                              input logic [7:0] sel);
        logic [16:0] w;
        logic [15:0] r;
        w = {1'b0, a} + {1'b0, b};
        r = old;
        if (sel[UPD_N]) r[BIT_NEGATIVE] = w[15];
        if (sel[UPD_Z]) r[BIT_ZERO] = (w[15:0] == 16'h0000);
        if (sel[UPD_V]) r[BIT_OVERFLOW] = (a[15] == b[15]) && (w[15] != a[15]);
        if (sel[UPD_C]) r[BIT_CARRY] = w[16];
        if (sel[UPD_H]) r[BIT_HALF_CARRY] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
        return r;
    endfunction

    initial begin
        forever #20 clock_in = ~clock_in;
    end

    initial begin
        void'($urandom(26004));
        repeat (10) @(negedge clock_in);
        check(status_word_out, 16'h0000);
        rst_b_in = 1'b1;
        @(negedge clock_in);
        for (int i = 0; i < 6; i++) begin
            sw = (i == 0) ? 16'hffff : 16'($urandom());
            write_sw(sw);
            check(status_word_out, sw);
        end
        // back-to-back updates; unselected flags must hold
        flag_update_in = 1'b1;
        for (int i = 0; i < 24; i++) begin
            {op_a, op_b} = (i < 3) ? corner[i] : 32'($urandom());
            flag_select_in = (i < 3) ? 8'h1f : {3'h0, 5'($urandom())};
            sw = add_flags(status_word_out, op_a, op_b, flag_select_in);
            @(negedge clock_in);
            check(status_word_out, sw);
        end
        // carry select plus shift select: carry takes the shifted-out bit
        for (int i = 0; i < 2; i++) begin
            flag_select_in = 8'h88;
            shift_out_in = (i == 0);
            @(negedge clock_in);
            check(status_word_out[BIT_CARRY], i == 0);
        end
        flag_update_in = 1'b0;
        for (int i = 0; i < 4; i++) begin
            sw = {8'h00, 8'($urandom())};
            pc_in = 16'($urandom());
            write_sw(sw);
            check(fetch_addr_out, {sw[PCX_MSB:PCX_LSB], pc_in});
            irq_req_in = 1'b1;
            for (int l = 0; l < 8; l++) begin
                irq_level_in = 3'(l);
                @(negedge clock_in);
                check(irq_take_out, (3'(l) > sw[PRIO_MSB:PRIO_LSB]) || l == 7);
            end
            irq_req_in = 1'b0;
            @(negedge clock_in);
            check(irq_take_out, 1'b0);
        end
        for (int s = 0; s < 2; s++) begin
            write_sw({s[0], 15'h0000});
            halt_exec_in = 1'b1;
            @(negedge clock_in);
            halt_exec_in = 1'b0;
            check({core_clock_stop_out, halt_nop_out}, {~s[0], s[0]});
            // stop stands until wake; a halt while stopped is ignored
            for (int k = 0; k < 3; k++) begin
                halt_exec_in = (k == 1) && !s[0];
                @(negedge clock_in);
                check({core_clock_stop_out, halt_nop_out}, {~s[0], 1'b0});
            end
            halt_exec_in = 1'b0;
            wake_in = 1'b1;
            @(negedge clock_in);
            wake_in = 1'b0;
            check({core_clock_stop_out, halt_nop_out}, 2'b00);
        end
        write_sw(16'h0010);
        for (int i = 0; i < 3; i++) begin
            mac_load_in = 1'b1;
            mac_wdata_in = mac_tab[i];
            @(negedge clock_in);
            mac_load_in = 1'b0;
            acc_read_in = 1'b1;
            acc_read_rounded_in = i[0];
            check(mac_accumulator_out, mac_tab[i]);
            check(status_word_out[BIT_MAC_HI_OVF], i > 0);
            check(status_word_out[BIT_MAC_EXT_OVF], 1'b1);
            @(negedge clock_in);
            acc_read_in = 1'b0;
            check(acc_read_data_out, sat_tab[i]);
        end
        // clearing both overflow flags lifts saturation; rounding adds bit 15
        flag_update_in = 1'b1;
        flag_select_in = 8'h60;
        mac_load_in = 1'b1;
        mac_wdata_in = 36'h0_1234_8000;
        @(negedge clock_in);
        flag_update_in = 1'b0;
        mac_load_in = 1'b0;
        check(status_word_out, 16'h0010);
        for (int r = 0; r < 2; r++) begin
            acc_read_in = 1'b1;
            acc_read_rounded_in = r[0];
            @(negedge clock_in);
            acc_read_in = 1'b0;
            check(acc_read_data_out, 16'h1234 + 16'(r));
        end
        // bit 34 alone differs from bit 31: still an extension overflow
        mac_load_in = 1'b1;
        mac_wdata_in = 36'h4_0000_0000;
        @(negedge clock_in);
        mac_load_in = 1'b0;
        check(status_word_out, 16'h1010);
        end_of_test();
    end
endmodule
